// [verilog/sto_defines.svh]
`ifndef STO_DEFINES_SVH
`define STO_DEFINES_SVH

`define STO_CLK_PERIOD_NS       10
`define STO_CNT_W               32
`define STO_PWM_W               2
`define STO_CHECK_PULSE_NS      1000000
`define STO_REJECT_CYCLES       ((`STO_CHECK_PULSE_NS + `STO_CLK_PERIOD_NS - 1) / `STO_CLK_PERIOD_NS)
`define STO_DIAG_PULSE_NS       200000
`define STO_DIAG_PULSE_CYCLES   (`STO_DIAG_PULSE_NS / `STO_CLK_PERIOD_NS)
`define STO_DIAG_PERIOD_NS      10000000
`define STO_DIAG_PERIOD_CYCLES  (`STO_DIAG_PERIOD_NS / `STO_CLK_PERIOD_NS)
`define STO_MONITOR_NS          20000000
`define STO_MONITOR_CYCLES      (`STO_MONITOR_NS / `STO_CLK_PERIOD_NS)
`define STO_PATH_SETTLE_NS      500000
`define STO_PATH_SETTLE_CYCLES  ((`STO_PATH_SETTLE_NS + `STO_CLK_PERIOD_NS - 1) / `STO_CLK_PERIOD_NS)
`define STO_RST_LEVEL           1'b0
`define STO_RST_GATE            1'b1

`endif

// [verilog/sto_pkg.sv]
`default_nettype none
`include "sto_defines.svh"

package sto_pkg;

  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_MONITOR = 4'h2,
    ST_STOPPED = 4'h4,
    ST_ERROR   = 4'h8
  } mon_state_type;

  typedef enum logic [1:0] {
    DG_IDLE  = 2'h1,
    DG_PULSE = 2'h2
  } diag_state_type;

  typedef struct packed {
    logic                   sync1;
    logic                   sync2;
    logic                   level;
    logic                   check_seen;
    logic [`STO_CNT_W-1:0]  low_cnt;
  } filter_state_type;

  typedef struct packed {
    logic                   mon_s1;
    logic                   mon_s2;
    diag_state_type         state;
    logic [`STO_CNT_W-1:0]  cnt;
    logic                   seen_low;
    logic                   gate;
    logic                   fault;
  } diag_reg_type;

  typedef struct packed {
    logic [3:0]             cmp_s1;
    logic [3:0]             cmp_s2;
    mon_state_type          state;
    logic [`STO_CNT_W-1:0]  mon_cnt;
    logic                   error;
    logic [`STO_CNT_W-1:0]  period_cnt;
    logic                   diag_sel;
    logic                   start_a;
    logic                   start_b;
    logic [`STO_CNT_W-1:0]  path_cnt;
    logic                   path_fault;
    logic                   uv_p;
    logic                   uv_s;
    logic                   ready;
    logic                   trip;
    logic [`STO_PWM_W-1:0]  pwm;
    logic                   gate_drive;
    logic                   en_a;
    logic                   en_b;
    logic                   stop_trig;
    logic                   alarm;
  } monitor_reg_type;

endpackage : sto_pkg

`default_nettype wire

// [verilog/stop_input_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sto_defines.svh"

module stop_input_filter #(
  parameter int unsigned REJECT_CYCLES = `STO_REJECT_CYCLES
) (
  input  wire logic ref_clk_i,     // System clock
  input  wire logic resetn_i,      // Async reset, active low
  input  wire logic raw_i,         // Receiver output pin
  output logic      level_o,       // Filtered stop-request level
  output logic      check_seen_o   // Pulse: a short check pulse ended
);

  sto_pkg::filter_state_type q, d;

  always_comb begin
    d            = q;
    d.sync1      = raw_i;
    d.sync2      = q.sync1;
    d.check_seen = 1'b0;
    if (q.sync2) begin
      // Receiver proved it can go low and come back while still filtered
      if (q.low_cnt != '0 && q.level) begin
        d.check_seen = 1'b1;
      end
      d.low_cnt = '0;
      d.level   = 1'b1;
    end else if (q.low_cnt < REJECT_CYCLES) begin
      // Lows up to the check-pulse length never reach the supplies
      d.low_cnt = q.low_cnt + 32'h1;
    end else begin
      d.level = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o      = q.level;
  assign check_seen_o = q.check_seen;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_reject_short;
    $fell(level_o) |-> $past(q.low_cnt) == REJECT_CYCLES;
  endproperty
  a_reject_short : assert property (p_reject_short) else $error("filtered low too early");

  property p_release_fast;
    q.sync2 |=> level_o;
  endproperty
  a_release_fast : assert property (p_release_fast) else $error("level did not return high");

endmodule : stop_input_filter

`default_nettype wire

// [verilog/supply_diag_pulse.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sto_defines.svh"

module supply_diag_pulse #(
  parameter int unsigned PULSE_CYCLES = `STO_DIAG_PULSE_CYCLES
) (
  input  wire logic ref_clk_i,   // System clock
  input  wire logic resetn_i,    // Async reset, active low
  input  wire logic start_i,     // Start one diagnostic off-pulse
  input  wire logic monitor_i,   // Switch output readback pin
  input  wire logic clear_i,     // Software reset of the fault
  output logic      gate_o,      // Channel gate, low during the pulse
  output logic      busy_o,      // Pulse in progress
  output logic      fault_o      // Switch failed to follow a pulse
);

  sto_pkg::diag_reg_type q, d;

  always_comb begin
    d        = q;
    d.mon_s1 = monitor_i;
    d.mon_s2 = q.mon_s1;
    d.fault  = q.fault & ~clear_i;
    case (q.state)
      sto_pkg::DG_IDLE: begin
        d.gate = 1'b1;
        if (start_i) begin
          d.state    = sto_pkg::DG_PULSE;
          d.cnt      = '0;
          d.seen_low = 1'b0;
          d.gate     = 1'b0;
        end
      end
      sto_pkg::DG_PULSE: begin
        d.cnt = q.cnt + 32'h1;
        if (!q.mon_s2) begin
          d.seen_low = 1'b1;
        end
        if (q.cnt == PULSE_CYCLES - 1) begin
          d.state = sto_pkg::DG_IDLE;
          d.gate  = 1'b1;
          // Set wins over a same-cycle clear
          if (!q.seen_low && q.mon_s2) begin
            d.fault = 1'b1;
          end
        end
      end
      default: begin
        d.state = sto_pkg::DG_IDLE;
        d.gate  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q       <= '0;
      q.state <= sto_pkg::DG_IDLE;
      q.gate  <= `STO_RST_GATE;
    end else begin
      q <= d;
    end
  end

  assign gate_o  = q.gate;
  assign busy_o  = (q.state == sto_pkg::DG_PULSE);
  assign fault_o = q.fault;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_pulse_end;
    busy_o && q.cnt == PULSE_CYCLES - 1 |=> gate_o && !busy_o;
  endproperty
  a_pulse_end : assert property (p_pulse_end) else $error("diagnostic pulse length wrong");

  property p_fault_on_stuck;
    busy_o && q.cnt == PULSE_CYCLES - 1 && !q.seen_low && q.mon_s2 |=> fault_o;
  endproperty
  a_fault_on_stuck : assert property (p_fault_on_stuck) else $error("stuck switch not flagged");

endmodule : supply_diag_pulse

`default_nettype wire

// [verilog/safe_stop_monitor.sv]
// Functional notes
// - Channel A off cuts primary driver supply; channel B off cuts secondary supply.
// - Either stop-request channel withdrawn sets the stop-triggered status.
// - After stop triggers, wait a fixed interval, then check both channels inactive.
// - Channels still disagreeing at interval end raise the discrepancy error.
// - Both low: stopped, no error; one low: monitor then error; both high: run.
// - Check pulses of 1 ms are ignored; supplies stay up throughout.
// - Receiver outputs are observed during check pulses to confirm the receiver works.
// - Secondary switch is pulsed off 200 us and read back through its monitor.
// - Primary switch is pulsed off 200 us and read back through its monitor.
// - Primary supply switch follows one logic-level on/off control.
// - Primary undervoltage forces driver output off until above upper threshold.
// - Secondary undervoltage forces driver output off until above upper threshold.
// - Driver ready is low when either supply is insufficient, else high.
// - Ready is sampled to verify each channel's path to its supply.
// - Stop-derived trip forces PWM low until software reset.
// - Driver output held low while output-side supply is absent.
// - Either stop input at 0 past the 1 ms reject window switches its own supply off; both 1 to run.
// - Each filtered channel is ANDed with a gating output for self-diagnosis.
`timescale 1ns/1ps
`default_nettype none
`include "sto_defines.svh"

module safe_stop_monitor #(
  parameter int unsigned REJECT_CYCLES      = `STO_REJECT_CYCLES,
  parameter int unsigned DIAG_PULSE_CYCLES  = `STO_DIAG_PULSE_CYCLES,
  parameter int unsigned DIAG_PERIOD_CYCLES = `STO_DIAG_PERIOD_CYCLES,
  parameter int unsigned MONITOR_CYCLES     = `STO_MONITOR_CYCLES,
  parameter int unsigned PATH_SETTLE_CYCLES = `STO_PATH_SETTLE_CYCLES
) (
  input  wire logic                  ref_clk_i,              // 100 MHz system clock
  input  wire logic                  resetn_i,               // Async reset, active low
  input  wire logic                  stop_request_ch_a_i,    // Receiver output, channel A pin
  input  wire logic                  stop_request_ch_b_i,    // Receiver output, channel B pin
  input  wire logic                  primary_monitor_i,      // Primary switch readback pin
  input  wire logic                  secondary_monitor_i,    // Secondary switch readback pin
  input  wire logic                  primary_below_low_i,    // Primary supply under lower threshold
  input  wire logic                  primary_above_high_i,   // Primary supply over upper threshold
  input  wire logic                  secondary_below_low_i,  // Secondary supply under lower threshold
  input  wire logic                  secondary_above_high_i, // Secondary supply over upper threshold
  input  wire logic [`STO_PWM_W-1:0] pwm_i,                  // PWM from the timer
  input  wire logic                  sw_reset_i,             // Software reset of latched state
  output logic                       driver_primary_supply_en_o,   // Primary supply switch on
  output logic                       driver_secondary_supply_en_o, // Secondary supply switch on
  output logic                       input_gate_ctrl_a_o,    // Gate for channel A
  output logic                       input_gate_ctrl_b_o,    // Gate for channel B
  output logic                       stop_triggered_o,       // Stop status
  output logic                       discrepancy_error_o,    // Channels disagreed too long
  output logic                       check_pulse_seen_a_o,   // Check pulse seen on A
  output logic                       check_pulse_seen_b_o,   // Check pulse seen on B
  output logic                       primary_diag_fault_o,   // Primary switch diag fault
  output logic                       secondary_diag_fault_o, // Secondary switch diag fault
  output logic                       path_fault_o,           // Ready disagrees with supplies
  output logic                       primary_undervoltage_lock_o,   // Primary lockout
  output logic                       secondary_undervoltage_lock_o, // Secondary lockout
  output logic                       driver_ready_o,         // Both supplies sufficient
  output logic                       driver_fault_alarm_o,   // Any latched fault
  output logic                       gate_drive_o,           // Gate-driver output
  output logic [`STO_PWM_W-1:0]      pwm_o,                  // PWM after trip
  output logic                       pwm_trip_o              // Trip latched
);

  sto_pkg::monitor_reg_type q, d;

  logic filt_a;
  logic filt_b;
  logic gate_a;
  logic gate_b;
  logic busy_a;
  logic busy_b;
  logic stop_any;
  logic both_low;
  logic mismatch;

  // Check pulses from the controller arrive no faster than 500 Hz, so one
  // counter per channel is enough to tell them from real removals
  stop_input_filter #(
    .REJECT_CYCLES (REJECT_CYCLES)
  ) u_filter_a (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .raw_i        (stop_request_ch_a_i),
    .level_o      (filt_a),
    .check_seen_o (check_pulse_seen_a_o)
  );

  stop_input_filter #(
    .REJECT_CYCLES (REJECT_CYCLES)
  ) u_filter_b (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .raw_i        (stop_request_ch_b_i),
    .level_o      (filt_b),
    .check_seen_o (check_pulse_seen_b_o)
  );

  supply_diag_pulse #(
    .PULSE_CYCLES (DIAG_PULSE_CYCLES)
  ) u_diag_primary (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (q.start_a),
    .monitor_i (primary_monitor_i),
    .clear_i   (sw_reset_i),
    .gate_o    (gate_a),
    .busy_o    (busy_a),
    .fault_o   (primary_diag_fault_o)
  );

  supply_diag_pulse #(
    .PULSE_CYCLES (DIAG_PULSE_CYCLES)
  ) u_diag_secondary (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (q.start_b),
    .monitor_i (secondary_monitor_i),
    .clear_i   (sw_reset_i),
    .gate_o    (gate_b),
    .busy_o    (busy_b),
    .fault_o   (secondary_diag_fault_o)
  );

  assign stop_any = ~(filt_a & filt_b);
  assign both_low = ~filt_a & ~filt_b;
  assign mismatch = ((q.en_a & q.en_b) != q.ready);

  always_comb begin
    d        = q;
    d.cmp_s1 = {secondary_above_high_i, secondary_below_low_i,
                primary_above_high_i, primary_below_low_i};
    d.cmp_s2 = q.cmp_s1;

    // Supplies follow the gated channels with no extra delay
    d.en_a      = filt_a & gate_a;    // Single on/off level for the primary switch
    d.en_b      = filt_b & gate_b;
    d.stop_trig = stop_any;

    // Discrepancy supervisor
    case (q.state)
      sto_pkg::ST_RUN: begin
        if (stop_any) begin
          d.state   = sto_pkg::ST_MONITOR;
          d.mon_cnt = '0;
        end
      end
      sto_pkg::ST_MONITOR: begin
        d.mon_cnt = q.mon_cnt + 32'h1;
        if (q.mon_cnt == MONITOR_CYCLES - 1) begin
          if (both_low) begin
            d.state = sto_pkg::ST_STOPPED;
          end else if (stop_any) begin
            d.state = sto_pkg::ST_ERROR;
            d.error = 1'b1;
          end else begin
            d.state = sto_pkg::ST_RUN;
          end
        end
      end
      sto_pkg::ST_STOPPED: begin
        if (!stop_any) begin
          d.state = sto_pkg::ST_RUN;
        end else if (!both_low) begin
          d.state   = sto_pkg::ST_MONITOR;
          d.mon_cnt = '0;
        end
      end
      sto_pkg::ST_ERROR: begin
        // Held until software resets it, then re-evaluated from run
        if (sw_reset_i) begin
          d.state = sto_pkg::ST_RUN;
          d.error = 1'b0;
        end
      end
      default: begin
        d.state = sto_pkg::ST_MONITOR;
        d.mon_cnt = '0;
      end
    endcase

    // Periodic switch diagnostics, alternating so one supply is always up
    d.start_a = 1'b0;
    d.start_b = 1'b0;
    if (q.state == sto_pkg::ST_RUN && !busy_a && !busy_b) begin
      if (q.period_cnt >= DIAG_PERIOD_CYCLES - 1) begin
        d.period_cnt = '0;
        d.diag_sel   = ~q.diag_sel;
        d.start_a    = ~q.diag_sel;
        d.start_b    = q.diag_sel;
      end else begin
        d.period_cnt = q.period_cnt + 32'h1;
      end
    end else begin
      d.period_cnt = '0;
    end

    // Undervoltage lockouts with hysteresis
    if (q.cmp_s2[0]) begin
      d.uv_p = 1'b1;
    end else if (q.cmp_s2[1]) begin
      d.uv_p = 1'b0;
    end
    if (q.cmp_s2[2]) begin
      d.uv_s = 1'b1;
    end else if (q.cmp_s2[3]) begin
      d.uv_s = 1'b0;
    end
    d.ready = ~(d.uv_p | d.uv_s);

    // Clear before set, so a mismatch still over the limit wins the cycle
    if (sw_reset_i) begin
      d.path_fault = 1'b0;
    end
    // Ready must track the supply enables once the rails settle; the
    // diagnostic pulses are masked since hold-up capacitors keep ready high
    if (mismatch && !busy_a && !busy_b) begin
      if (q.path_cnt >= PATH_SETTLE_CYCLES - 1) begin
        d.path_fault = 1'b1;
      end else begin
        d.path_cnt = q.path_cnt + 32'h1;
      end
    end else begin
      d.path_cnt = '0;
    end

    // Trip latch: a new stop wins over a same-cycle software reset
    d.trip = stop_any | (q.trip & ~sw_reset_i);
    d.pwm  = d.trip ? '0 : pwm_i;
    // Output held low while either supply is locked out
    d.gate_drive = d.pwm[0] & d.ready;

    d.alarm = d.error | d.path_fault | primary_diag_fault_o | secondary_diag_fault_o;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q       <= '0;
      q.state <= sto_pkg::ST_MONITOR;
      q.uv_p  <= 1'b1;
      q.uv_s  <= 1'b1;
      q.trip  <= 1'b1;
      q.en_a  <= `STO_RST_LEVEL;
      q.en_b  <= `STO_RST_LEVEL;
      q.stop_trig <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign driver_primary_supply_en_o    = q.en_a;
  assign driver_secondary_supply_en_o  = q.en_b;
  assign input_gate_ctrl_a_o           = gate_a;
  assign input_gate_ctrl_b_o           = gate_b;
  assign stop_triggered_o              = q.stop_trig;
  assign discrepancy_error_o           = q.error;
  assign path_fault_o                  = q.path_fault;
  assign primary_undervoltage_lock_o   = q.uv_p;
  assign secondary_undervoltage_lock_o = q.uv_s;
  assign driver_ready_o                = q.ready;
  assign driver_fault_alarm_o          = q.alarm;
  assign gate_drive_o                  = q.gate_drive;
  assign pwm_o                         = q.pwm;
  assign pwm_trip_o                    = q.trip;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_primary_cut;
    !filt_a |=> !driver_primary_supply_en_o;
  endproperty
  a_primary_cut : assert property (p_primary_cut) else $error("primary supply not cut");

  property p_secondary_cut;
    !filt_b |=> !driver_secondary_supply_en_o;
  endproperty
  a_secondary_cut : assert property (p_secondary_cut) else $error("secondary supply not cut");

  property p_stop_status;
    (!filt_a || !filt_b) |=> stop_triggered_o;
  endproperty
  a_stop_status : assert property (p_stop_status) else $error("stop status missing");

  property p_error_at_end;
    q.state == sto_pkg::ST_MONITOR && q.mon_cnt == MONITOR_CYCLES - 1 && (filt_a != filt_b)
      |=> discrepancy_error_o;
  endproperty
  a_error_at_end : assert property (p_error_at_end) else $error("discrepancy not flagged");

  property p_no_early_error;
    !discrepancy_error_o && !(q.state == sto_pkg::ST_MONITOR && q.mon_cnt == MONITOR_CYCLES - 1)
      |=> !discrepancy_error_o;
  endproperty
  a_no_early_error : assert property (p_no_early_error) else $error("error before interval");

  property p_error_latched;
    discrepancy_error_o && !sw_reset_i |=> discrepancy_error_o;
  endproperty
  a_error_latched : assert property (p_error_latched) else $error("error dropped");

  property p_trip_pwm;
    pwm_trip_o && !sw_reset_i |=> pwm_trip_o && pwm_o == '0;
  endproperty
  a_trip_pwm : assert property (p_trip_pwm) else $error("pwm not held by trip");

  property p_uv_output_off;
    (primary_undervoltage_lock_o || secondary_undervoltage_lock_o) |-> !gate_drive_o && !driver_ready_o;
  endproperty
  a_uv_output_off : assert property (p_uv_output_off) else $error("output on under lockout");

  property p_ready_follows;
    driver_ready_o == !(primary_undervoltage_lock_o || secondary_undervoltage_lock_o);
  endproperty
  a_ready_follows : assert property (p_ready_follows) else $error("ready wrong");

  property p_primary_gate;
    !input_gate_ctrl_a_o |=> !driver_primary_supply_en_o;
  endproperty
  a_primary_gate : assert property (p_primary_gate) else $error("gate a ignored");

  property p_secondary_gate;
    !input_gate_ctrl_b_o |=> !driver_secondary_supply_en_o;
  endproperty
  a_secondary_gate : assert property (p_secondary_gate) else $error("gate b ignored");

  property p_one_pulse;
    input_gate_ctrl_a_o || input_gate_ctrl_b_o;
  endproperty
  a_one_pulse : assert property (p_one_pulse) else $error("both supplies pulsed");

  property p_primary_on;
    filt_a && input_gate_ctrl_a_o |=> driver_primary_supply_en_o;
  endproperty
  a_primary_on : assert property (p_primary_on) else $error("primary switch not on");

  property p_drive_ready;
    gate_drive_o |-> driver_ready_o && !pwm_trip_o;
  endproperty
  a_drive_ready : assert property (p_drive_ready) else $error("drive without supply");

endmodule : safe_stop_monitor

`default_nettype wire

// [sim/sto_plc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sto_plc_model #(
  parameter int unsigned GAP  = 60, // Min spacing of check pulses
  parameter int unsigned HOLD = 12  // Supply hold-up, longer than a diag pulse
) (
  input  wire logic       ref_clk_i, // Clock
  input  wire logic [1:0] req_i,     // Stop levels, bit 0 is channel A
  input  wire logic       chk_i,     // Start a check pulse
  input  wire logic [4:0] len_i,     // Check pulse length
  input  wire logic [1:0] en_i,      // Supply switch enables
  input  wire logic [1:0] stuck_i,   // Readback stuck high
  input  wire logic [1:0] uv_i,      // Force a supply low
  output logic      [1:0] sto_o,     // Stop inputs
  output logic      [1:0] mon_o,     // Switch readbacks
  output logic      [1:0] low_o      // Supply under lower threshold
);
  int unsigned gap_q = 0;
  int unsigned len_q = 0;
  int unsigned off_q[2] = '{0, 0};

  always @(posedge ref_clk_i) begin
    if (gap_q != 0) gap_q <= gap_q - 1;
    if (len_q != 0) len_q <= len_q - 1;
    else if (chk_i && gap_q == 0) begin
      len_q <= len_i;
      gap_q <= GAP;
    end
    for (int i = 0; i < 2; i++) begin
      off_q[i] <= en_i[i] ? 0 : off_q[i] + 1;
      mon_o[i] <= en_i[i] | stuck_i[i];
    end
  end
  assign sto_o = req_i & {2{len_q == 0}};
  assign low_o = {off_q[1] >= HOLD, off_q[0] >= HOLD} | uv_i;
endmodule : sto_plc_model
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned DP = 8;
  localparam int unsigned MN = 50;
  logic clk, rst_n, chk, swr, trip, trip_p, st, err, pfa, pfb, pth, rdy, gd, alarm;
  logic [1:0] req, stuck, uv, pwm, sto, mon, low, en, gate, seen, sn, ul, pwm_o;
  logic [4:0] len;
  int   miscompares = 0, checked = 0, lo[2] = '{0, 0};

  safe_stop_monitor #(.REJECT_CYCLES(20), .DIAG_PULSE_CYCLES(DP), .DIAG_PERIOD_CYCLES(100),
    .MONITOR_CYCLES(MN), .PATH_SETTLE_CYCLES(30)) u_dut (
    .ref_clk_i(clk), .resetn_i(rst_n), .stop_request_ch_a_i(sto[0]),
    .stop_request_ch_b_i(sto[1]), .primary_monitor_i(mon[0]), .secondary_monitor_i(mon[1]),
    .primary_below_low_i(low[0]), .primary_above_high_i(!low[0]),
    .secondary_below_low_i(low[1]), .secondary_above_high_i(!low[1]), .pwm_i(pwm),
    .sw_reset_i(swr), .driver_primary_supply_en_o(en[0]),
    .driver_secondary_supply_en_o(en[1]), .input_gate_ctrl_a_o(gate[0]),
    .input_gate_ctrl_b_o(gate[1]), .stop_triggered_o(st), .discrepancy_error_o(err),
    .check_pulse_seen_a_o(sn[0]), .check_pulse_seen_b_o(sn[1]), .primary_diag_fault_o(pfa),
    .secondary_diag_fault_o(pfb), .path_fault_o(pth), .primary_undervoltage_lock_o(ul[0]),
    .secondary_undervoltage_lock_o(ul[1]), .driver_ready_o(rdy),
    .driver_fault_alarm_o(alarm), .gate_drive_o(gd), .pwm_o(pwm_o), .pwm_trip_o(trip));

  sto_plc_model u_plc (.ref_clk_i(clk), .req_i(req), .chk_i(chk), .len_i(len), .en_i(en),
    .stuck_i(stuck), .uv_i(uv), .sto_o(sto), .mon_o(mon), .low_o(low));

  function automatic logic exp_stop(input logic [1:0] r);
    return !(&r);
  endfunction : exp_stop

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic pulse_sw;
    swr = 1'b1;
    cyc(1);
    swr = 1'b0;
    cyc(3);
  endtask : pulse_sw

  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Random PWM keeps the trip gating exercised all run long
  always @(negedge clk) begin
    pwm <= 2'($urandom_range(3, 0));
    trip_p <= trip;
    if (rst_n && trip && trip_p) cmp("pwm_o", 8'h0, 8'(pwm_o));
    if (rst_n && !trip) cmp("pwm_pass", 8'(pwm), 8'(pwm_o));
    if (rst_n && !trip && rdy) cmp("drive_on", 8'(pwm[0]), 8'(gd));
    for (int i = 0; i < 2; i++) begin
      if (!rst_n) lo[i] = 0;
      else if (!gate[i]) lo[i]++;
      else if (lo[i] != 0) begin
        cmp("gate_len", 8'(DP), 8'(lo[i]));
        lo[i] = 0;
      end
    end
  end

  always @(posedge clk) seen <= rst_n ? (seen | sn) : 2'h0;

  initial begin
    cyc(10000);
    miscompares++;
    stop_test;
  end

  initial begin
    rst_n = 0; req = 2'h3; chk = 0; len = 5'h1; stuck = 2'h0; uv = 2'h0; swr = 0;
    void'($urandom(49));
    cyc(5);
    rst_n = 1;
    cyc(40);
    cmp("trip", 8'h1, 8'(trip));
    pulse_sw;
    cmp("trip", 8'h0, 8'(trip));
    // Check pulses of 1 to 18 cycles, shorter than the reject window, must leave the supplies up
    repeat (6) begin
      len = 5'($urandom_range(18, 1));
      chk = 1'b1;
      cyc(1);
      chk = 1'b0;
      repeat (65) begin
        cmp("stop", 8'h0, 8'(st));
        cmp("ready", 8'h1, 8'(rdy));
        cyc(1);
      end
    end
    cmp("seen", 8'h3, 8'(seen));
    cmp("diag", 8'h0, 8'({pfb, pfa}));
    for (int r = 0; r < 3; r++) begin
      req = 2'(r);
      cyc(40);
      cmp("stop", 8'(exp_stop(req)), 8'(st));
      cmp("en", 8'(r), 8'(en));
      pulse_sw;
      cmp("trip", 8'h1, 8'(trip));
      cyc(MN + 40);
      cmp("err", 8'(^req), 8'(err));
      cmp("ready", 8'h0, 8'(rdy));
      cmp("drive", 8'h0, 8'(gd));
      req = 2'h3;
      cyc(40);
      cmp("err", 8'(r != 0), 8'(err));
      pulse_sw;
      cmp("err", 8'h0, 8'({trip, err}));
      cmp("stop", 8'h0, 8'(st));
    end
    for (int i = 1; i < 3; i++) begin
      stuck = 2'(i);
      cyc(240);
      cmp("diag", 8'(i), 8'({pfb, pfa}));
      cmp("alarm", 8'h1, 8'(alarm));
      stuck = 2'h0;
      pulse_sw;
      cmp("diag", 8'h0, 8'({pfb, pfa}));
    end
    for (int i = 1; i < 3; i++) begin
      uv = 2'(i);
      cyc(8);
      cmp("lock", 8'(i), 8'(ul));
      repeat (40) begin
        cmp("drive", 8'h0, 8'(gd));
        cmp("ready", 8'h0, 8'(rdy));
        cyc(1);
      end
      uv = 2'h0;
      cyc(8);
      cmp("ready", 8'h1, 8'(rdy));
      cmp("path", 8'h1, 8'(pth));
      pulse_sw;
      cmp("path", 8'h0, 8'(pth));
    end
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
